// ===== rtl/occ_channel.sv
// What this block does
// R1: timebase_select picks third timer, else second
// R2: compare timer to one or two values
// R3: pin changes when timer equals compare value
// R4: mode 000 disables, no pin, no interrupt
// R5: mode 001 low start, match forces high
// R6: mode 010 high start, match forces low
// R7: mode 011 keeps level, match toggles pin
// R8: mode 100 single pulse between two compares
// R9: mode 101 repeated pulses, interrupt on fall
// R10: mode 110 PWM, start level from primary
// R11: mode 111 PWM, interrupt on fault fall
// R12: fault flag read-only, hardware cleared
// R13: idle_stop_bit halts channel in CPU idle; mode 111 fault edges still act (flag, fault event, pin low)
// R14: software stops timer before control writes
// R15: compare matches can raise interrupts
// R16: PWM: duty match inactive, rollover reloads duty from secondary, active
// R17: fault forces pin inactive until mode rewritten
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/1ps
module occ_channel
    import occ_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire occ_pkg::occ_req_t req,
    output logic [15:0] rdata,
    // time base and cpu state
    input wire occ_pkg::occ_tb_t tb,
    input wire logic cpu_idle,
    // fault input, active low
    input wire logic fault_input_a_n,
    // pin and interrupt
    output logic compare_output_pin,
    output logic pin_enable,
    output logic irq
);
    import occ_pkg::*;

    // whole state of the channel
    typedef struct packed {
        logic [2:0] mode;
        logic tsel;
        logic sidl;
        logic flt;
        logic [15:0] pri;
        logic [15:0] sec;
        logic [15:0] duty;
        logic pin;
        logic armed;
        logic flt_prev;
        logic [2:0] istat;
        logic [2:0] imask;
        logic [15:0] rdata;
    } occ_state_t;

    occ_state_t s_reg; // registered state
    occ_state_t s_next; // next state
    logic [15:0] tval; // selected timer value
    logic troll; // selected timer rollover
    logic run; // channel not halted
    logic m_pri; // primary match
    logic m_sec; // secondary match
    logic fault_fall; // fault input falling edge
    logic [2:0] ev; // events this cycle
    logic [15:0] ctrl_rd; // control readback
    logic [2:0] wmode; // written mode field

    // initial pin level for a newly written mode
    function automatic logic init_level(input logic [2:0] m, input logic [15:0] p,
                                        input logic cur);
        case (m)
            OCC_M_HIGH1: init_level = 1'b1;
            OCC_M_TOG: init_level = cur;
            OCC_M_PWM, OCC_M_PWMF: init_level = (p != 16'h0000);
            default: init_level = 1'b0;
        endcase
    endfunction

    // time base selection and matches
    always_comb
    begin
        tval = s_reg.tsel ? tb.t3_val : tb.t2_val; // R1
        troll = s_reg.tsel ? tb.t3_roll : tb.t2_roll; // R1
        run = !(s_reg.sidl && cpu_idle); // R13
        m_pri = run && (tval == s_reg.pri); // R2
        m_sec = run && (tval == s_reg.sec); // R2
        fault_fall = s_reg.flt_prev && !fault_input_a_n;
        wmode = req.wdata[OCC_MODE_LSB +: 3];
    end

    // control register readback layout
    always_comb
    begin
        ctrl_rd = 16'h0000;
        ctrl_rd[OCC_MODE_LSB +: 3] = s_reg.mode;
        ctrl_rd[OCC_TSEL_BIT] = s_reg.tsel;
        ctrl_rd[OCC_FLT_BIT] = s_reg.flt;
        ctrl_rd[OCC_SIDL_BIT] = s_reg.sidl;
    end

    // next-state logic: mode behaviour, registers, interrupts
    always_comb
    begin
        s_next = s_reg;
        ev = 3'h0;
        s_next.flt_prev = fault_input_a_n;
        // mode behaviour
        case (occ_mode_t'(s_reg.mode))
            OCC_M_OFF:
            begin
                s_next.pin = 1'b0; // R4
            end
            OCC_M_LOW1:
            begin
                if (m_pri && !s_reg.pin)
                begin
                    s_next.pin = 1'b1; // R5
                    ev[OCC_EV_EDGE] = 1'b1; // R5
                end
            end
            OCC_M_HIGH1:
            begin
                if (m_pri && s_reg.pin)
                begin
                    s_next.pin = 1'b0; // R6
                    ev[OCC_EV_EDGE] = 1'b1; // R6
                end
            end
            OCC_M_TOG:
            begin
                if (m_pri)
                begin
                    s_next.pin = !s_reg.pin; // R7 R3
                    ev[OCC_EV_EDGE] = 1'b1; // R7
                end
            end
            OCC_M_DLY1, OCC_M_CONT:
            begin
                // rise on primary, fall on secondary
                if (m_pri && !s_reg.pin && s_reg.armed)
                begin
                    s_next.pin = 1'b1; // R8 R9
                end
                else if (m_sec && s_reg.pin)
                begin
                    s_next.pin = 1'b0; // R8 R9
                    ev[OCC_EV_EDGE] = 1'b1; // R8 R9
                    // one-shot disarms; continuous stays armed
                    s_next.armed = (s_reg.mode == OCC_M_CONT); // R8 R9
                end
            end
            OCC_M_PWM, OCC_M_PWMF:
            begin
                if (s_reg.mode == OCC_M_PWMF && fault_fall)
                begin
                    s_next.flt = 1'b1; // R11 R12 R17
                    s_next.pin = 1'b0; // R17
                    ev[OCC_EV_FAULT] = 1'b1; // R11
                end
                else if (!s_reg.flt && run && troll)
                begin
                    s_next.duty = s_reg.sec; // R16
                    s_next.pin = (s_reg.sec != 16'h0000); // R16
                end
                else if (!s_reg.flt && run && tval == s_reg.duty)
                begin
                    s_next.pin = 1'b0; // R16
                end
            end
            default:
            begin
                s_next.pin = s_reg.pin;
            end
        endcase
        // match event only when enabled, except PWM with no interrupt
        if (s_reg.mode != OCC_M_OFF && s_reg.mode != OCC_M_PWM && m_pri)
        begin
            ev[OCC_EV_MATCH] = 1'b1; // R15
        end
        // register write; software clear loses to same-cycle set
        s_next.istat = s_reg.istat | ev;
        if (req.wr)
        begin
            case (req.addr)
                OCC_ADDR_CTRL:
                begin
                    s_next.mode = wmode;
                    s_next.tsel = req.wdata[OCC_TSEL_BIT];
                    s_next.sidl = req.wdata[OCC_SIDL_BIT];
                    // a fault in the same cycle outlasts the rewrite
                    s_next.flt = ev[OCC_EV_FAULT]; // R12 R17
                    s_next.armed = 1'b1;
                    s_next.duty = s_reg.pri; // R16
                    if (ev[OCC_EV_FAULT])
                    begin
                        s_next.pin = 1'b0; // R17
                    end
                    else
                    begin
                        s_next.pin = init_level(wmode, s_reg.pri, s_reg.pin); // R10
                    end
                end
                OCC_ADDR_PRI: s_next.pri = req.wdata;
                OCC_ADDR_SEC: s_next.sec = req.wdata;
                OCC_ADDR_ISTAT: s_next.istat = (s_reg.istat & ~req.wdata[2:0]) | ev;
                OCC_ADDR_IMASK: s_next.imask = req.wdata[2:0];
                default: s_next.imask = s_reg.imask;
            endcase
        end
        // read data, next cycle only
        s_next.rdata = 16'h0000;
        if (req.rd)
        begin
            case (req.addr)
                OCC_ADDR_CTRL: s_next.rdata = ctrl_rd;
                OCC_ADDR_PRI: s_next.rdata = s_reg.pri;
                OCC_ADDR_SEC: s_next.rdata = s_reg.sec;
                OCC_ADDR_ISTAT: s_next.rdata = {13'h0000, s_reg.istat};
                OCC_ADDR_IMASK: s_next.rdata = {13'h0000, s_reg.imask};
                default: s_next.rdata = 16'h0000;
            endcase
        end
    end

    // state register
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_reg <= '0;
            s_reg.pri <= OCC_CMP_RST;
            s_reg.sec <= OCC_CMP_RST;
            s_reg.istat <= OCC_IRQ_RST;
            s_reg.imask <= OCC_IRQ_RST;
            s_reg.flt_prev <= 1'b1;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // outputs
    assign rdata = s_reg.rdata;
    assign compare_output_pin = s_reg.pin;
    assign pin_enable = (s_reg.mode != OCC_M_OFF); // R4
    assign irq = |(s_reg.istat & s_reg.imask);

    // assertions
    // disabled channel leaves the pin to the port
    off_no_pin_a: assert property (@(posedge clk) disable iff (rst) // R4
        s_reg.mode == OCC_M_OFF |-> !pin_enable && !compare_output_pin)
        else $error("disabled channel drives pin");
    // disabled channel raises no event
    off_quiet_a: assert property (@(posedge clk) disable iff (rst) // R4
        s_reg.mode == OCC_M_OFF && !req.wr |=> $stable(s_reg.istat))
        else $error("disabled channel raised an event");
    // low-start one-shot rises on the match
    low_rise_a: assert property (@(posedge clk) disable iff (rst) // R5
        s_reg.mode == OCC_M_LOW1 && m_pri && !s_reg.pin && !req.wr
        |=> compare_output_pin && s_reg.istat[OCC_EV_EDGE])
        else $error("one-shot high missed");
    // high-start one-shot falls on the match
    high_fall_a: assert property (@(posedge clk) disable iff (rst) // R6
        s_reg.mode == OCC_M_HIGH1 && m_pri && s_reg.pin && !req.wr
        |=> !compare_output_pin && s_reg.istat[OCC_EV_EDGE])
        else $error("one-shot low missed");
    // toggle mode inverts the pin on every match
    toggle_pin_a: assert property (@(posedge clk) disable iff (rst) // R7 R3
        s_reg.mode == OCC_M_TOG && m_pri && !req.wr
        |=> compare_output_pin != $past(compare_output_pin) && s_reg.istat[OCC_EV_EDGE])
        else $error("toggle missed");
    // armed pulse modes rise on the primary match
    pulse_rise_a: assert property (@(posedge clk) disable iff (rst) // R8 R9 R2
        (s_reg.mode == OCC_M_DLY1 || s_reg.mode == OCC_M_CONT) && m_pri && !s_reg.pin
        && s_reg.armed && !req.wr |=> compare_output_pin)
        else $error("pulse rise missed");
    // pulse modes fall on the secondary match
    pulse_fall_a: assert property (@(posedge clk) disable iff (rst) // R8 R9
        (s_reg.mode == OCC_M_DLY1 || s_reg.mode == OCC_M_CONT) && m_sec && s_reg.pin
        && !req.wr |=> !compare_output_pin && s_reg.istat[OCC_EV_EDGE])
        else $error("pulse fall missed");
    // single pulse disarms after its fall
    shot_disarm_a: assert property (@(posedge clk) disable iff (rst) // R8
        s_reg.mode == OCC_M_DLY1 && m_sec && s_reg.pin && !req.wr |=> !s_reg.armed)
        else $error("one-shot pulse still armed");
    // pwm start level follows the primary value
    pwm_init_a: assert property (@(posedge clk) disable iff (rst) // R10
        req.wr && req.addr == OCC_ADDR_CTRL && wmode[2:1] == 2'b11 && !ev[OCC_EV_FAULT]
        |=> compare_output_pin == (s_reg.pri != 16'h0000))
        else $error("pwm start level wrong");
    // a control write takes the primary value as duty
    duty_entry_a: assert property (@(posedge clk) disable iff (rst) // R16
        req.wr && req.addr == OCC_ADDR_CTRL |=> s_reg.duty == $past(s_reg.pri))
        else $error("pwm entry duty wrong");
    // plain pwm raises no event
    pwm_quiet_a: assert property (@(posedge clk) disable iff (rst) // R10
        s_reg.mode == OCC_M_PWM && !req.wr |=> $stable(s_reg.istat))
        else $error("plain pwm raised an event");
    // rollover reloads duty from the secondary value
    roll_reload_a: assert property (@(posedge clk) disable iff (rst) // R16
        s_reg.mode[2:1] == 2'b11 && !s_reg.flt && run && troll && !fault_fall && !req.wr
        |=> s_reg.duty == s_reg.sec && compare_output_pin == (s_reg.sec != 16'h0000))
        else $error("pwm reload missed");
    // duty match ends the active phase
    pwm_off_a: assert property (@(posedge clk) disable iff (rst) // R16 R3
        s_reg.mode[2:1] == 2'b11 && !s_reg.flt && run && !troll && tval == s_reg.duty
        && !fault_fall && !req.wr |=> !compare_output_pin)
        else $error("pwm duty end missed");
    // fault steps: the edge is seen, then the pin stays low
    sequence fault_seen_s;
        s_reg.mode == OCC_M_PWMF && fault_fall && !req.wr;
    endsequence
    sequence fault_held_s;
        s_reg.flt && !compare_output_pin && s_reg.istat[OCC_EV_FAULT]
        ##1 (!compare_output_pin || $past(req.wr));
    endsequence
    // a fault forces the pin low until control is rewritten
    fault_hold_a: assert property (@(posedge clk) disable iff (rst) // R11 R12 R17
        fault_seen_s |=> fault_held_s)
        else $error("fault not held");
    // a fault beside a control rewrite still wins
    fault_wins_a: assert property (@(posedge clk) disable iff (rst) // R12 R17
        req.wr && req.addr == OCC_ADDR_CTRL && s_reg.mode == OCC_M_PWMF && fault_fall
        |=> s_reg.flt && !compare_output_pin)
        else $error("fault lost to control write");
    // a control write with no fault clears the flag
    flt_clear_a: assert property (@(posedge clk) disable iff (rst) // R12
        req.wr && req.addr == OCC_ADDR_CTRL && !fault_fall |=> !s_reg.flt)
        else $error("fault flag not cleared");
    // idle stop freezes the compare modes
    idle_halt_a: assert property (@(posedge clk) disable iff (rst) // R13
        s_reg.sidl && cpu_idle && s_reg.mode != OCC_M_OFF && s_reg.mode[2:1] != 2'b11
        && !req.wr |=> $stable(compare_output_pin))
        else $error("idle halt failed");
    // idle stop freezes pwm too, faults aside
    idle_pwm_a: assert property (@(posedge clk) disable iff (rst) // R13
        s_reg.sidl && cpu_idle && s_reg.mode[2:1] == 2'b11 && !fault_fall && !req.wr
        |=> $stable(compare_output_pin))
        else $error("idle pwm halt failed");
    // the selected timer's match lands as a match event
    tsel_pick_a: assert property (@(posedge clk) disable iff (rst) // R1 R15
        s_reg.mode != OCC_M_OFF && s_reg.mode != OCC_M_PWM && run
        && (s_reg.tsel ? tb.t3_val : tb.t2_val) == s_reg.pri |=> s_reg.istat[OCC_EV_MATCH])
        else $error("time base select wrong");
endmodule

// ===== common/occ_pkg.sv
package occ_pkg;
    // register indices on the plain port
    localparam logic [2:0] OCC_ADDR_CTRL = 3'h0;   // compare_channel_control
    localparam logic [2:0] OCC_ADDR_PRI = 3'h1;    // primary_compare_value
    localparam logic [2:0] OCC_ADDR_SEC = 3'h2;    // secondary_compare_value
    localparam logic [2:0] OCC_ADDR_ISTAT = 3'h3;  // sticky event status
    localparam logic [2:0] OCC_ADDR_IMASK = 3'h4;  // event mask
    // control field positions
    localparam int OCC_MODE_LSB = 0;
    localparam int OCC_TSEL_BIT = 3;
    localparam int OCC_FLT_BIT = 4;
    localparam int OCC_SIDL_BIT = 13;
    // reset values
    localparam logic [15:0] OCC_CTRL_RST = 16'h0000;
    localparam logic [15:0] OCC_CMP_RST = 16'h0000;
    localparam logic [2:0] OCC_IRQ_RST = 3'h0;
    // status bits: output edge event, fault event, compare match event
    localparam int OCC_EV_EDGE = 0;
    localparam int OCC_EV_FAULT = 1;
    localparam int OCC_EV_MATCH = 2;

    // compare_mode_field encodings
    typedef enum logic [2:0] {
        OCC_M_OFF = 3'b000,
        OCC_M_LOW1 = 3'b001,
        OCC_M_HIGH1 = 3'b010,
        OCC_M_TOG = 3'b011,
        OCC_M_DLY1 = 3'b100,
        OCC_M_CONT = 3'b101,
        OCC_M_PWM = 3'b110,
        OCC_M_PWMF = 3'b111
    } occ_mode_t;

    // register port request
    typedef struct packed {
        logic [2:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } occ_req_t;

    // time base from the two timers
    typedef struct packed {
        logic [15:0] t2_val;
        logic t2_roll;
        logic [15:0] t3_val;
        logic t3_roll;
    } occ_tb_t;
endpackage

// ===== dv/occ_timer_model.sv
`timescale 1ns/1ps
// second and third timers as seen by the channel
module occ_timer_model
    import occ_pkg::*;
#(
    parameter int PER2 = 16, // second timer period
    parameter int PER3 = 40  // third timer period
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // software run gate
    input wire logic run,
    // time base
    output occ_pkg::occ_tb_t tb
);
    // count up, pulse rollover; stopped timers sit at zero
    always_ff @(posedge clk)
    begin
        if (rst || !run)
        begin
            tb <= '0;
        end
        else
        begin
            tb.t2_roll <= (tb.t2_val == 16'(PER2 - 1));
            tb.t2_val <= (tb.t2_val == 16'(PER2 - 1)) ? 16'h0000 : tb.t2_val + 16'h0001;
            tb.t3_roll <= (tb.t3_val == 16'(PER3 - 1));
            tb.t3_val <= (tb.t3_val == 16'(PER3 - 1)) ? 16'h0000 : tb.t3_val + 16'h0001;
        end
    end
endmodule

// ===== dv/occ_channel_bench.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin bad_count++; \
    $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module occ_channel_bench;
    import occ_pkg::*;
    // stimulus and observed signals
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic run = 1'b0;
    logic cpu_idle = 1'b0;
    logic fault_input_a_n = 1'b1;
    occ_req_t req = '0;
    occ_tb_t tb;
    logic [15:0] rdata;
    logic pin;
    logic pin_en;
    logic irq;
    logic [15:0] d; // last read word
    int bad_count = 0;
    int checks_done = 0;
    always #2 clk = ~clk;
    occ_timer_model #(.PER2(16), .PER3(40)) tmr (.clk(clk), .rst(rst), .run(run), .tb(tb));
    occ_channel dut (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .tb(tb),
        .cpu_idle(cpu_idle), .fault_input_a_n(fault_input_a_n),
        .compare_output_pin(pin), .pin_enable(pin_en), .irq(irq));
    // one-cycle write strobe
    task automatic wr(input logic [2:0] a, input logic [15:0] v);
        @(posedge clk);
        req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
        #1;
    endtask
    // one-cycle read strobe, data taken in the following cycle
    task automatic rd(input logic [2:0] a);
        @(posedge clk);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask
    // bounded wait for a pin level
    task automatic wait_pin(input logic v, input string nm);
        int n;
        n = 0;
        while (pin !== v && n < 60)
        begin
            @(posedge clk);
            #1 n++;
        end
        `CHK(nm, v, pin)
    endtask
    // stop timer, load compares and control, clear events
    task automatic cfg(input logic [15:0] p, input logic [15:0] s, input logic [15:0] c);
        @(posedge clk) run <= 1'b0;
        wr(OCC_ADDR_PRI, p);
        wr(OCC_ADDR_SEC, s);
        wr(OCC_ADDR_CTRL, c);
        wr(OCC_ADDR_ISTAT, 16'h0007);
    endtask
    task automatic t_reset();
        for (int i = 0; i < 8; i++)
        begin
            rd(3'(i));
            `CHK("reg after reset", 16'h0000, d)
        end
        `CHK("pin owner", 1'b0, pin_en)
        $display("test reset done");
    endtask
    task automatic t_modes();
        logic [7:0] init;
        init = 8'hcc;
        cfg(16'h0005, 16'h0008, 16'h0000);
        for (int m = 0; m < 8; m++)
        begin
            wr(OCC_ADDR_CTRL, 16'(m));
            `CHK("initial pin", init[m], pin)
            `CHK("pin owner", (m != 0), pin_en)
        end
        $display("test modes done");
    endtask
    task automatic t_shot(input logic [15:0] c, input logic [15:0] p, input logic lvl);
        wr(OCC_ADDR_IMASK, 16'h0001);
        cfg(p, 16'h0000, c);
        `CHK("start level", ~lvl, pin)
        @(posedge clk) run <= 1'b1;
        wait_pin(lvl, "match level");
        #8;
        `CHK("edge irq", 1'b1, irq)
        rd(OCC_ADDR_ISTAT);
        `CHK("edge and match", 3'h5, d[2:0])
        wr(OCC_ADDR_ISTAT, 16'h0001);
        `CHK("irq cleared", 1'b0, irq)
        $display("test one-shot done");
    endtask
    task automatic t_pulse(input logic [15:0] c, input int n);
        int falls;
        logic last;
        falls = 0;
        cfg(16'h0003, 16'h0008, c);
        last = pin;
        @(posedge clk) run <= 1'b1;
        repeat (50)
        begin
            @(posedge clk);
            #1 falls += int'(last && !pin);
            last = pin;
        end
        `CHK("falling edges", n, falls)
        $display("test pulse done");
    endtask
    task automatic t_toggle();
        int flips;
        logic last;
        flips = 0;
        cfg(16'h0005, 16'h0000, 16'h0003);
        last = pin;
        wr(OCC_ADDR_CTRL, 16'h0003);
        `CHK("toggle keeps level", last, pin)
        @(posedge clk) run <= 1'b1;
        repeat (50)
        begin
            @(posedge clk);
            #1 flips += int'(last !== pin);
            last = pin;
        end
        `CHK("toggles", 32'h00000003, flips)
        rd(OCC_ADDR_ISTAT);
        `CHK("toggle events", 3'h5, d[2:0])
        $display("test toggle done");
    endtask
    task automatic t_idle();
        cfg(16'h0005, 16'h0000, 16'h2001);
        @(posedge clk)
        begin
            cpu_idle <= 1'b1;
            run <= 1'b1;
        end
        repeat (40) @(posedge clk);
        #1 `CHK("held in idle", 1'b0, pin)
        @(posedge clk) cpu_idle <= 1'b0;
        wait_pin(1'b1, "resumed");
        cfg(16'h0005, 16'h0000, 16'h0001);
        @(posedge clk)
        begin
            cpu_idle <= 1'b1;
            run <= 1'b1;
        end
        wait_pin(1'b1, "runs in idle");
        @(posedge clk) cpu_idle <= 1'b0;
        $display("test idle done");
    endtask
    task automatic t_pwm();
        wr(OCC_ADDR_IMASK, 16'h0007);
        cfg(16'h0005, 16'h0008, 16'h0006);
        @(posedge clk) run <= 1'b1;
        wait_pin(1'b0, "duty end");
        wait_pin(1'b1, "period start");
        `CHK("pwm irq", 1'b0, irq)
        cfg(16'h0005, 16'h0008, 16'h0007);
        @(posedge clk)
        begin
            fault_input_a_n <= 1'b0;
            run <= 1'b1;
        end
        repeat (40) @(posedge clk);
        #1 `CHK("fault pin", 1'b0, pin)
        `CHK("fault irq", 1'b1, irq)
        rd(OCC_ADDR_CTRL);
        `CHK("fault flag", 16'h0017, d)
        @(posedge clk) fault_input_a_n <= 1'b1;
        cfg(16'h0005, 16'h0008, 16'h0017);
        rd(OCC_ADDR_CTRL);
        `CHK("flag cleared", 16'h0007, d)
        $display("test pwm done");
    endtask
    // verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_modes();
        t_shot(16'h0001, 16'h0005, 1'b1);
        t_shot(16'h000a, 16'h001e, 1'b0);
        t_pulse(16'h0004, 1);
        t_pulse(16'h0005, 3);
        t_toggle();
        t_idle();
        t_pwm();
        results();
    end
    // watchdog against a hang
    initial
    begin
        repeat (4000) @(posedge clk);
        bad_count++;
        results();
    end
endmodule
